// ### src/dio_pkg.sv
// Shared constants for the pin-side DDR input and output register block
package dio_pkg;
   // ------------------------------------------------------------------
   // Register map and bus answers
   // ------------------------------------------------------------------
   localparam int         ADDR_W        = 4;
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // ------------------------------------------------------------------
   // Control register fields and reset value
   // ------------------------------------------------------------------
   localparam int         CTRL_DDR_IN   = 0;
   localparam int         CTRL_POLARITY = 1;
   localparam int         CTRL_DDR_OUT  = 2;
   localparam int         CTRL_LATCH    = 3;
   localparam int         CTRL_W        = 4;
   localparam logic [3:0] CTRL_RESET    = 4'h0;

   // ------------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------------
   localparam int STAT_SDR     = 0;
   localparam int STAT_RISE    = 1;
   localparam int STAT_FALL    = 2;
   localparam int STAT_PAD_OUT = 3;
   localparam int STAT_OUT_CLK = 4;

   // ------------------------------------------------------------------
   // Timing: output clock half period derived from the system clock
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 25;
   localparam int OUT_HALF_NS     = 50;
   localparam int OUT_HALF_CYCLES = (OUT_HALF_NS / CLK_PERIOD_NS < 1) ? 1
                                    : OUT_HALF_NS / CLK_PERIOD_NS;
endpackage

// ### src/dio_out_if.sv
// Signals between the block top and its output register stage
`timescale 1ns/1ps
`default_nettype none
interface dio_out_if;
   logic dataFirst;
   logic dataSecond;
   logic ddrMode;
   logic latchMode;
   logic clockEnable;
   logic syncReset;
   logic outClk;
   logic outClkRise;
   logic padOut;

   modport source (output dataFirst, dataSecond, ddrMode, latchMode,
                   clockEnable, syncReset, outClk, outClkRise,
                   input padOut);
   modport sink   (input dataFirst, dataSecond, ddrMode, latchMode,
                   clockEnable, syncReset, outClk, outClkRise,
                   output padOut);
endinterface
`default_nettype wire

// ### src/dio_out_reg.sv
// Output register stage: SDR flop or latch, DDR latch and clock mux
`timescale 1ns/1ps
`default_nettype none
module dio_out_reg (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Core side
   dio_out_if.sink   ob
);
   logic sdrReg;
   logic ddrLatch;
   logic latchLoaded;

   // SDR register: edge flop, or transparent while the clock is high
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sdrReg <= 1'b0;
      end else if (ob.syncReset) begin
         sdrReg <= 1'b0;
      end else if (ob.clockEnable) begin
         if (ob.ddrMode || !ob.latchMode) begin
            if (ob.outClkRise) begin
               sdrReg <= ob.dataFirst;
            end
         end else if (ob.outClk) begin
            sdrReg <= ob.dataFirst;
         end
      end
   end

   // DDR latch: open while the clock is high, no reset or enable
   always_ff @(posedge clk_sys) begin
      if (ob.outClk) begin
         ddrLatch <= ob.dataSecond;
      end
   end

   // Marks the latch as holding a real value since reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latchLoaded <= 1'b0;
      end else if (ob.outClk) begin
         latchLoaded <= 1'b1;
      end
   end

   // Clock driven mux toward the pad
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ob.padOut <= 1'b0;
      end else if (ob.ddrMode && !ob.outClk && latchLoaded) begin
         ob.padOut <= ddrLatch;
      end else begin
         ob.padOut <= sdrReg;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   ddr_mux_low_a: assert property (
      (ob.ddrMode && !ob.outClk && latchLoaded) |=>
         ob.padOut == $past(ddrLatch))
      else $error("DDR low phase does not drive the latch");
   latch_hold_a: assert property (
      (!ob.outClk && latchLoaded) |=> $stable(ddrLatch))
      else $error("DDR latch changed while closed");
   sdr_hold_a: assert property (
      (!ob.clockEnable && !ob.syncReset) |=> $stable(sdrReg))
      else $error("SDR output register moved without enable");
   ddr_out_c: cover property (ob.ddrMode && $fell(ob.outClk));
endmodule
`default_nettype wire

// ### src/dio_ddr_io_block.sv
// Pin-side SDR/DDR input and output register block with AXI4-Lite control
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - SDR input: pad data lands in one sync register on the system clock
// - DDR input: strobe rising and falling edges each capture pad data
// - Both strobe streams are re-registered on the system clock for core
// - Polarity select picks true or inverted timing of sync registers
// - Input SDR and sync registers have a reset and a clock enable
// - SDR output: first data feeds one flop or latch that drives the pad
// - DDR output: first data flopped on rising clock, second data latched
// - A mux run by the output clock picks which stored value drives pad
// - The SDR output register has a reset and a clock enable
// - The DDR-only latch has neither reset nor clock enable
// - Input may bypass registers as a plain signal or as a clock
module dio_ddr_io_block (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      reset_n,
   // AXI4-Lite write address and data
   input  wire logic [dio_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output var  logic                      s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output var  logic                      s_axi_wready,
   // AXI4-Lite write response
   output var  logic [1:0]                s_axi_bresp,
   output var  logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read
   input  wire logic [dio_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output var  logic                      s_axi_arready,
   output var  logic [31:0]               s_axi_rdata,
   output var  logic [1:0]                s_axi_rresp,
   output var  logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Pads from the external device
   input  wire logic                      linkStrobe,
   input  wire logic                      padInputData,
   // Core side input controls
   input  wire logic                      inputClockEnable,
   input  wire logic                      inputSyncReset,
   // Core side input data
   output var  logic                      sdrInputData,
   output var  logic                      risingEdgeStream,
   output var  logic                      fallingEdgeStream,
   output var  logic                      inputDataValid,
   output var  logic                      bypassCombinationalInput,
   output var  logic                      bypassClockInput,
   // Core side output data and controls
   input  wire logic                      outputDataFirst,
   input  wire logic                      outputDataSecond,
   input  wire logic                      outputClockEnable,
   input  wire logic                      outputSyncReset,
   // Pads toward the external device
   output var  logic                      padOutputData,
   output var  logic                      outputClock
);
   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [dio_pkg::CTRL_W-1:0] ctrl;
   logic strobeMeta, strobeSync, strobeLast;
   logic padMeta, padSync;
   logic strobeRise, strobeFall;
   logic risingCapture, fallingCapture;
   logic fallDone, fallDone2, syncLoad;
   logic [7:0] halfCnt;
   logic outClkRise;
   logic awHeld, wHeld;
   logic [dio_pkg::ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;
   logic next_awHeld, next_wHeld, next_rvalid;
   logic ddrIn, polarity;
   dio_out_if ob ();
   assign ddrIn      = ctrl[dio_pkg::CTRL_DDR_IN];
   assign polarity   = ctrl[dio_pkg::CTRL_POLARITY];
   assign strobeRise = strobeSync & ~strobeLast;
   assign strobeFall = ~strobeSync & strobeLast;

   // ------------------------------------------------------------------
   // Pad synchronisers and strobe edge finder
   // ------------------------------------------------------------------
   // Two flops per pad; logic uses the second stage, plus a third strobe flop for edge finding
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         strobeMeta <= 1'b0;
         strobeSync <= 1'b0;
         strobeLast <= 1'b0;
         padMeta    <= 1'b0;
         padSync    <= 1'b0;
      end else begin
         strobeMeta <= linkStrobe;
         strobeSync <= strobeMeta;
         strobeLast <= strobeSync;
         padMeta    <= padInputData;
         padSync    <= padMeta;
      end
   end
   // Bypass paths to the core, one flop after the synchronisers, no enable
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bypassCombinationalInput <= 1'b0;
         bypassClockInput         <= 1'b0;
      end else begin
         bypassCombinationalInput <= padSync;
         bypassClockInput         <= strobeSync;
      end
   end

   // ------------------------------------------------------------------
   // Input capture
   // ------------------------------------------------------------------
   // SDR input register on the system clock
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sdrInputData <= 1'b0;
      end else if (inputSyncReset) begin
         sdrInputData <= 1'b0;
      end else if (inputClockEnable && !ddrIn) begin
         sdrInputData <= padSync;
      end
   end
   // Strobe edge capture into two streams
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         risingCapture  <= 1'b0;
         fallingCapture <= 1'b0;
      end else if (ddrIn) begin
         if (strobeRise) begin
            risingCapture <= padSync;
         end
         if (strobeFall) begin
            fallingCapture <= padSync;
         end
      end
   end
   // Load timing: true polarity one stage, inverted one stage later
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fallDone  <= 1'b0;
         fallDone2 <= 1'b0;
      end else begin
         fallDone  <= ddrIn & strobeFall;
         fallDone2 <= fallDone;
      end
   end
   assign syncLoad = polarity ? fallDone2 : fallDone;
   // Sync registers hand both streams to the core
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         risingEdgeStream  <= 1'b0;
         fallingEdgeStream <= 1'b0;
         inputDataValid    <= 1'b0;
      end else if (inputSyncReset) begin
         risingEdgeStream  <= 1'b0;
         fallingEdgeStream <= 1'b0;
         inputDataValid    <= 1'b0;
      end else begin
         inputDataValid <= syncLoad & inputClockEnable;
         if (syncLoad && inputClockEnable) begin
            risingEdgeStream  <= risingCapture;
            fallingEdgeStream <= fallingCapture;
         end
      end
   end

   // ------------------------------------------------------------------
   // Output clock divider
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         halfCnt     <= 8'h00;
         outputClock <= 1'b0;
         outClkRise  <= 1'b0;
      end else if (halfCnt == 8'(dio_pkg::OUT_HALF_CYCLES - 1)) begin
         halfCnt     <= 8'h00;
         outputClock <= ~outputClock;
         outClkRise  <= ~outputClock;
      end else begin
         halfCnt    <= halfCnt + 8'h01;
         outClkRise <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Output register stage
   // ------------------------------------------------------------------
   assign ob.dataFirst   = outputDataFirst;
   assign ob.dataSecond  = outputDataSecond;
   assign ob.ddrMode     = ctrl[dio_pkg::CTRL_DDR_OUT];
   assign ob.latchMode   = ctrl[dio_pkg::CTRL_LATCH];
   assign ob.clockEnable = outputClockEnable;
   assign ob.syncReset   = outputSyncReset;
   assign ob.outClk      = outputClock;
   assign ob.outClkRise  = outClkRise;
   assign padOutputData  = ob.padOut;

   dio_out_reg u_out (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .ob      (ob.sink)
   );

   // ------------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------------
   // Next state of the address, data and read holding flags
   always_comb begin
      doWrite     = awHeld & wHeld & ~s_axi_bvalid;
      next_awHeld = awHeld;
      next_wHeld  = wHeld;
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
      end
      next_rvalid = s_axi_rvalid ? ~s_axi_rready
                                 : (s_axi_arvalid & s_axi_arready);
   end

   // Write channels, control register and response
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= '0;
         wData         <= 32'h0000_0000;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= dio_pkg::RESP_OKAY;
         ctrl          <= dio_pkg::CTRL_RESET;
      end else begin
         awHeld        <= next_awHeld;
         wHeld         <= next_wHeld;
         s_axi_awready <= ~next_awHeld;
         s_axi_wready  <= ~next_wHeld;
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (awAddr[3:2] == dio_pkg::CTRL_OFFSET[3:2]) begin
               s_axi_bresp <= dio_pkg::RESP_OKAY;
               if (wStrb[0]) begin
                  ctrl <= wData[dio_pkg::CTRL_W-1:0];
               end
            end else begin
               s_axi_bresp <= dio_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // Read channel: control and live status
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= dio_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid  <= next_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dio_pkg::RESP_OKAY;
            if (s_axi_araddr[3:2] == dio_pkg::CTRL_OFFSET[3:2]) begin
               s_axi_rdata[dio_pkg::CTRL_W-1:0] <= ctrl;
            end else if (s_axi_araddr[3:2] ==
                         dio_pkg::STATUS_OFFSET[3:2]) begin
               s_axi_rdata[dio_pkg::STAT_SDR]     <= sdrInputData;
               s_axi_rdata[dio_pkg::STAT_RISE]    <= risingEdgeStream;
               s_axi_rdata[dio_pkg::STAT_FALL]    <= fallingEdgeStream;
               s_axi_rdata[dio_pkg::STAT_PAD_OUT] <= padOutputData;
               s_axi_rdata[dio_pkg::STAT_OUT_CLK] <= outputClock;
            end else begin
               s_axi_rresp <= dio_pkg::RESP_SLVERR;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sdr_capture_a: assert property (
      (!ddrIn && inputClockEnable && !inputSyncReset) |=>
         sdrInputData == $past(padSync))
      else $error("SDR input did not capture pad data");
   rise_capture_a: assert property (
      (ddrIn && strobeRise) |=> risingCapture == $past(padSync))
      else $error("Rising strobe edge missed pad data");
   stream_transfer_a: assert property (
      (ddrIn && strobeFall && !polarity) ##1
      (inputClockEnable && !inputSyncReset) |=>
         fallingEdgeStream == $past(fallingCapture) && inputDataValid)
      else $error("Streams not re-registered after falling edge");
   inverted_delay_a: assert property (
      (fallDone && polarity && !fallDone2) ##1
      (inputClockEnable && !inputSyncReset) |=> inputDataValid)
      else $error("Inverted polarity load came at wrong cycle");
   sync_clear_a: assert property (
      inputSyncReset |=> !risingEdgeStream && !fallingEdgeStream
                         && !sdrInputData && !inputDataValid)
      else $error("Input reset did not clear registers");
   bypass_path_a: assert property (
      ##1 1'b1 |-> bypassCombinationalInput == $past(padSync))
      else $error("Bypass output does not follow pad");
   write_resp_a: assert property (
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
       && !s_axi_bvalid) |-> ##2 s_axi_bvalid)
      else $error("Write response not on time");
   ddr_in_c: cover property (inputDataValid && ddrIn);
   pol_inv_c: cover property (inputDataValid && polarity);
   sdr_in_c: cover property (!ddrIn && inputClockEnable);
   rd_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ### verif/dio_ddr_dev_model.sv
// Model of the external strobe and data source facing the pads
`timescale 1ns/1ps
`default_nettype none
module dio_ddr_dev_model (
   // Pads driven toward the block
   output logic linkStrobe,
   output logic padInputData
);
   // Strobe rests low between frames
   initial begin
      linkStrobe   = 1'b0;
      padInputData = 1'b0;
   end

   // Steady pad level for single rate capture
   task automatic setLevel(input logic v);
      padInputData = v;
   endtask

   // One 200 ns strobe period, each datum centred on its edge
   task automatic sendPair(input logic a, input logic b);
      #13 padInputData = a;
      #50 linkStrobe = 1'b1;
      #50 padInputData = b;
      #50 linkStrobe = 1'b0;
      #50 padInputData = ~b; // Hold over: line no longer shows b
   endtask
endmodule
`default_nettype wire

// ### verif/dio_ddr_io_block_test.sv
// Self-checking bench for the DDR input and output register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin \
   $display("[ERR] %s expected %0h seen %0h", nm, (ex), (got)); \
   badCount++; end end
module dio_ddr_io_block_test;
   logic        clkSys = 1'b0;
   logic        resetN = 1'b0;
   logic [3:0]  awAddr = 4'h0, arAddr = 4'h0;
   logic [31:0] wData = 32'h0, rData, rd;
   logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
   logic        arValid = 1'b0, rReady = 1'b0;
   logic        awReady, wReady, bValid, arReady, rValid;
   logic [1:0]  bResp, rResp, rs;
   logic        linkStrobe, padInputData;
   logic        inEn = 1'b1, inRst = 1'b0, outEn = 1'b1, outRst = 1'b0;
   logic        first = 1'b0, second = 1'b0;
   logic        sdrIn, riseS, fallS, inValid, byComb, byClk, padOut, outClk;
   int          badCount = 0, checksDone = 0, lat[2], n;

   // System clock, 25 ns period
   always #12.5 clkSys = ~clkSys;

   dio_ddr_dev_model dev (.linkStrobe(linkStrobe),
                          .padInputData(padInputData));

   dio_ddr_io_block uut (
      .clk_sys(clkSys), .reset_n(resetN),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .linkStrobe(linkStrobe), .padInputData(padInputData),
      .inputClockEnable(inEn), .inputSyncReset(inRst),
      .sdrInputData(sdrIn), .risingEdgeStream(riseS),
      .fallingEdgeStream(fallS), .inputDataValid(inValid),
      .bypassCombinationalInput(byComb), .bypassClockInput(byClk),
      .outputDataFirst(first), .outputDataSecond(second),
      .outputClockEnable(outEn), .outputSyncReset(outRst),
      .padOutputData(padOut), .outputClock(outClk));

   // Wait whole cycles
   task automatic hold(input int c);
      repeat (c) @(posedge clkSys);
   endtask

   // AXI4-Lite write: address and data offered together
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] r);
      @(posedge clkSys);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge clkSys);
         if (awValid && awReady === 1'b1) awValid <= 1'b0;
         if (wValid && wReady === 1'b1) wValid <= 1'b0;
      end while (bValid !== 1'b1);
      r = bResp;
      bReady <= 1'b0;
   endtask

   // AXI4-Lite read
   task automatic axiRead(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
      @(posedge clkSys);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge clkSys);
         if (arValid && arReady === 1'b1) arValid <= 1'b0;
      end while (rValid !== 1'b1);
      d = rData;
      r = rResp;
      rReady <= 1'b0;
   endtask

   // Send one strobe pair and count cycles to the valid pulse (40 = none)
   task automatic ddrPair(input logic a, input logic b, output int c);
      c = 0;
      @(posedge clkSys);
      fork
         dev.sendPair(a, b);
         do begin
            @(posedge clkSys);
            c++;
         end while (inValid !== 1'b1 && c < 40);
      join
   endtask

   // Pad follows the mux select of the previous cycle
   task automatic ddrOut(input logic hi, input logic lo);
      logic pc;
      pc = outClk;
      repeat (8) begin
         @(posedge clkSys);
         `CHK("ddr pad", pc ? hi : lo, padOut)
         pc = outClk;
      end
   endtask

   task automatic endTest(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic completeRun();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      hold(20000);
      badCount++;
      completeRun();
   end

   // Main sequence
   initial begin
      hold(2);
      resetN <= 1'b1;
      hold(3);
      axiRead(dio_pkg::CTRL_OFFSET, rd, rs);
      `CHK("ctrl reset", 32'h0, rd)
      axiRead(4'h8, rd, rs);
      `CHK("unmapped", dio_pkg::RESP_SLVERR, rs)
      axiWrite(dio_pkg::STATUS_OFFSET, 32'h1F, rs);
      `CHK("status wr", dio_pkg::RESP_SLVERR, rs)
      endTest("registers");
      for (int v = 0; v < 2; v++) begin
         dev.setLevel(v[0]);
         hold(6);
         `CHK("sdr in", v[0], sdrIn)
         `CHK("bypass", v[0], byComb)
      end
      inEn <= 1'b0;
      dev.setLevel(1'b0);
      hold(6);
      `CHK("sdr hold", 1'b1, sdrIn)
      axiRead(dio_pkg::STATUS_OFFSET, rd, rs);
      `CHK("status sdr", 1'b1, rd[dio_pkg::STAT_SDR])
      inEn <= 1'b1;
      hold(6);
      `CHK("sdr load", 1'b0, sdrIn)
      dev.setLevel(1'b1);
      inRst <= 1'b1;
      hold(6);
      `CHK("sdr clear", 1'b0, sdrIn)
      inRst <= 1'b0;
      endTest("sdr input");
      for (int p = 0; p < 2; p++) begin
         axiWrite(dio_pkg::CTRL_OFFSET, {30'h0, p[0], 1'b1}, rs);
         for (int k = 0; k < 2; k++) begin
            ddrPair(k[0], ~k[0], lat[p]);
            `CHK("rise", k[0], riseS)
            `CHK("fall", ~k[0], fallS)
         end
      end
      `CHK("polarity lag", lat[0] + 1, lat[1])
      `CHK("strobe bypass", 1'b0, byClk)
      inEn <= 1'b0;
      ddrPair(1'b1, 1'b1, n);
      `CHK("load skipped", 40, n)
      inEn <= 1'b1;
      endTest("ddr input");
      axiWrite(dio_pkg::CTRL_OFFSET, 32'h0, rs);
      first <= 1'b1;
      hold(8);
      `CHK("sdr out", 1'b1, padOut)
      outEn <= 1'b0;
      first <= 1'b0;
      hold(8);
      `CHK("sdr out hold", 1'b1, padOut)
      outEn <= 1'b1;
      outRst <= 1'b1;
      hold(8);
      `CHK("sdr out clear", 1'b0, padOut)
      outRst <= 1'b0;
      axiWrite(dio_pkg::CTRL_OFFSET, 32'h8, rs);
      first <= 1'b1;
      hold(8);
      `CHK("latch out", 1'b1, padOut)
      endTest("sdr output");
      axiWrite(dio_pkg::CTRL_OFFSET, 32'h4, rs);
      hold(8);
      ddrOut(1'b1, 1'b0);
      second <= 1'b1;
      outRst <= 1'b1;
      hold(8);
      ddrOut(1'b0, 1'b1);
      outRst <= 1'b0;
      endTest("ddr output");
      completeRun();
   end
endmodule
`default_nettype wire
